/* hw/aclw_pkg.sv */
package aclw_pkg;

  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_CTRL     = 8'h00;
  localparam logic [7:0] IDX_FLAGS    = 8'h01;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h02;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h03;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h04;
  localparam logic [7:0] IDX_EOL_INFO = 8'h10;
  localparam logic [7:0] IDX_CMD_B0   = 8'h14;
  localparam logic [7:0] IDX_CMD_B1   = 8'h15;

  // Control register fields
  localparam int CTRL_EN   = 0;
  localparam int CTRL_SR   = 1;
  localparam int CTRL_SMA  = 2;
  localparam int CTRL_RSTM = 3;
  localparam int CTRL_HALT = 4;
  localparam int CTRL_W    = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // End-of-list info fields
  localparam int EOL_LIST_BIT = 7;
  localparam int EOL_BUF_BIT  = 6;

  // Command word bits 31..16 held as a 16-bit word
  localparam int CW_BASE   = 16;
  localparam int CW_TYPE_H = 31 - CW_BASE;
  localparam int CW_TYPE_L = 30 - CW_BASE;
  localparam int CW_RSV_H  = 29 - CW_BASE;
  localparam int CW_RSV_L  = 28 - CW_BASE;
  localparam int CW_FSEL_H = 27 - CW_BASE;
  localparam int CW_FSEL_L = 24 - CW_BASE;
  localparam int CW_HREF   = 23 - CW_BASE;
  localparam int CW_LREF   = 22 - CW_BASE;
  localparam int CW_CH_H   = 21 - CW_BASE;
  localparam int CW_CH_L   = 16 - CW_BASE;
  localparam logic [15:0] CMD_RST = 16'h0000;

  // Command types
  localparam logic [1:0] CT_NORMAL  = 2'h0;
  localparam logic [1:0] CT_EOS     = 2'h1;
  localparam logic [1:0] CT_EOL_RUN = 2'h2;
  localparam logic [1:0] CT_EOL_WT  = 2'h3;

  // Channel code ranges
  localparam logic [5:0] CH_RSV_LO  = 6'h03;
  localparam logic [5:0] CH_RSV_HI  = 6'h08;
  localparam logic [5:0] CH_AN_BASE = 6'h10;

  // Interrupt status bits
  localparam int IRQ_EOL  = 0;
  localparam int IRQ_CONV = 1;
  localparam int IRQ_ERR  = 2;
  localparam int IRQ_W    = 3;

  typedef enum logic [1:0] {
    WAIT_NONE,
    WAIT_TRIG_OR_RST,
    WAIT_RST_THEN_TRIG
  } aclw_wait_e;

endpackage

/* hw/aclw_cmd_decode.sv */
`timescale 1ns/1ps
module aclw_cmd_decode #(
  parameter int unsigned NUM_AN = 8
) (
  input  logic                 [15:0] cmd_word,
  input  logic                        restart_mode,
  output logic                 [1:0]  cmd_type,
  output logic                        wrap,
  output aclw_pkg::aclw_wait_e        wait_mode,
  output logic                 [15:1] onehot,
  output logic                        is_eol,
  output logic                        high_ref,
  output logic                        low_ref,
  output logic                 [5:0]  channel,
  output logic                        reserved
);

  logic [3:0] fsel;
  logic [5:0] an_lim;

  assign cmd_type = cmd_word[aclw_pkg::CW_TYPE_H:aclw_pkg::CW_TYPE_L];
  assign fsel     = cmd_word[aclw_pkg::CW_FSEL_H:aclw_pkg::CW_FSEL_L];
  assign high_ref = cmd_word[aclw_pkg::CW_HREF];
  assign low_ref  = cmd_word[aclw_pkg::CW_LREF];
  assign channel  = cmd_word[aclw_pkg::CW_CH_H:aclw_pkg::CW_CH_L];
  assign is_eol   = cmd_type[1];
  assign an_lim   = 6'(aclw_pkg::CH_AN_BASE + 6'(NUM_AN));

  // Binary flag select to one-hot flag
  genvar gi;
  generate
    for (gi = 1; gi < 16; gi++) begin : g_flag
      assign onehot[gi] = (fsel == 4'(gi));
    end
  endgenerate

  always_comb begin
    wrap      = 1'b0;
    wait_mode = aclw_pkg::WAIT_NONE;
    unique case (cmd_type)
      aclw_pkg::CT_NORMAL: begin
        wait_mode = aclw_pkg::WAIT_NONE;
      end
      aclw_pkg::CT_EOS: begin
        wait_mode = aclw_pkg::WAIT_TRIG_OR_RST;
      end
      aclw_pkg::CT_EOL_RUN: begin
        wrap = 1'b1;
      end
      aclw_pkg::CT_EOL_WT: begin
        wrap      = 1'b1;
        wait_mode = restart_mode ? aclw_pkg::WAIT_RST_THEN_TRIG
                                 : aclw_pkg::WAIT_TRIG_OR_RST;
      end
    endcase
  end

  // Reserved field bits, reserved and unimplemented channels
  always_comb begin
    reserved = |cmd_word[aclw_pkg::CW_RSV_H:aclw_pkg::CW_RSV_L];
    if (channel >= aclw_pkg::CH_RSV_LO && channel <= aclw_pkg::CH_RSV_HI) begin
      reserved = 1'b1;
    end
    if (channel >= an_lim) begin
      reserved = 1'b1;
    end
  end

endmodule

/* hw/aclw_top.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////
module aclw_top #(
  parameter int unsigned NUM_AN = 8
) (
  input  logic                        CORE_CLK,
  input  logic                        SRST,
  input  logic                        PSEL,
  input  logic                        PENABLE,
  input  logic                        PWRITE,
  input  logic                 [11:0] PADDR,
  input  logic                 [31:0] PWDATA,
  output logic                 [31:0] PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  logic                        CMD_START,
  input  logic                        CMD_DONE,
  input  logic                        LIST_IN_USE,
  input  logic                        BUFFER_IN_USE,
  output logic                 [1:0]  CMD_TYPE,
  output logic                        LIST_WRAP,
  output aclw_pkg::aclw_wait_e        WAIT_MODE,
  output logic                        HIGH_REF_SEL,
  output logic                        LOW_REF_SEL,
  output logic                 [5:0]  INPUT_CHANNEL_SEL,
  output logic                 [15:0] CONV_FLAGS,
  output logic                        CONV_HALT,
  output logic                        IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                 [3:0]  ctrl_r;
  logic                 [15:0] cmd_word_r;
  logic                 [1:0]  eol_info_r;
  logic                 [15:0] flags_r;
  logic                 [15:0] flags_nxt;
  logic                 [2:0]  irq_stat_r;
  logic                 [2:0]  irq_stat_nxt;
  logic                 [2:0]  irq_en_r;
  logic                 [2:0]  irq_en_nxt;
  logic                        halt_r;
  logic                        pready_r;
  logic                        pslverr_r;
  logic                 [31:0] prdata_r;
  logic                        irq_r;
  logic                 [7:0]  idx;
  logic                        in_range;
  logic                        mapped;
  logic                        acc;
  logic                        wr;
  logic                 [31:0] rd_mux;
  logic                        mod_clear;
  logic                        sma;
  logic                        done_ok;
  logic                        start_ok;
  logic                 [15:0] flag_set;
  logic                 [15:0] flag_w1c;
  logic                 [2:0]  irq_evt;
  logic                 [2:0]  irq_w1c;
  logic                 [1:0]  dec_type;
  logic                        dec_wrap;
  aclw_pkg::aclw_wait_e        dec_wait;
  logic                 [15:1] dec_onehot;
  logic                        dec_is_eol;
  logic                        dec_href;
  logic                        dec_lref;
  logic                 [5:0]  dec_ch;
  logic                        dec_rsv;
  logic                 [1:0]  out_type_r;
  logic                        out_wrap_r;
  aclw_pkg::aclw_wait_e        out_wait_r;
  logic                        out_href_r;
  logic                        out_lref_r;
  logic                 [5:0]  out_ch_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  aclw_cmd_decode #(
    .NUM_AN (NUM_AN)
  ) u_dec (
    .cmd_word     (cmd_word_r),
    .restart_mode (ctrl_r[aclw_pkg::CTRL_RSTM]),
    .cmd_type     (dec_type),
    .wrap         (dec_wrap),
    .wait_mode    (dec_wait),
    .onehot       (dec_onehot),
    .is_eol       (dec_is_eol),
    .high_ref     (dec_href),
    .low_ref      (dec_lref),
    .channel      (dec_ch),
    .reserved     (dec_rsv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state

  assign idx      = PADDR[9:2];
  assign in_range = (PADDR[11:10] == 2'h0);
  assign acc      = PSEL & PENABLE & pready_r;
  assign wr       = acc & PWRITE;
  assign sma      = ctrl_r[aclw_pkg::CTRL_SMA];

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = in_range;
    unique case (idx)
      aclw_pkg::IDX_CTRL: begin
        rd_mux[3:0] = ctrl_r;
        rd_mux[aclw_pkg::CTRL_HALT] = halt_r;
      end
      aclw_pkg::IDX_FLAGS: begin
        rd_mux[15:0] = flags_r;
      end
      aclw_pkg::IDX_IRQ_STAT: begin
        rd_mux[2:0] = irq_stat_r;
      end
      aclw_pkg::IDX_IRQ_EN: begin
        rd_mux[2:0] = irq_en_r;
      end
      aclw_pkg::IDX_IRQ_CLR: begin
        rd_mux = 32'h0000_0000;
      end
      aclw_pkg::IDX_EOL_INFO: begin
        rd_mux[7:6] = eol_info_r;
      end
      aclw_pkg::IDX_CMD_B0: begin
        rd_mux[7:0] = cmd_word_r[15:8];
      end
      aclw_pkg::IDX_CMD_B1: begin
        rd_mux[7:0] = cmd_word_r[7:0];
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (!in_range) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (PSEL && PENABLE && !pready_r) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r  <= PWRITE ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and command registers

  assign mod_clear = ctrl_r[aclw_pkg::CTRL_SR] | ~ctrl_r[aclw_pkg::CTRL_EN];

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_r <= aclw_pkg::CTRL_RST;
    end else if (wr && in_range && idx == aclw_pkg::IDX_CTRL) begin
      ctrl_r <= PWDATA[aclw_pkg::CTRL_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      cmd_word_r <= aclw_pkg::CMD_RST;
    end else if (wr && in_range && sma) begin
      if (idx == aclw_pkg::IDX_CMD_B0) begin
        cmd_word_r[15:8] <= PWDATA[7:0];
      end
      if (idx == aclw_pkg::IDX_CMD_B1) begin
        cmd_word_r[7:0] <= PWDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer events, halt and end-of-list info

  assign done_ok  = CMD_DONE & ~halt_r & ~mod_clear;
  assign start_ok = CMD_START & ~halt_r & ~mod_clear;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      halt_r <= 1'b0;
    end else if (mod_clear) begin
      halt_r <= 1'b0;
    end else if (start_ok && dec_rsv) begin
      halt_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      eol_info_r <= 2'h0;
    end else if (mod_clear) begin
      eol_info_r <= 2'h0;
    end else if (done_ok && dec_is_eol) begin
      eol_info_r <= {LIST_IN_USE, BUFFER_IN_USE};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion flags, set wins over clear

  assign flag_set = done_ok ? {dec_onehot, dec_is_eol} : 16'h0000;
  assign flag_w1c = (wr && in_range && idx == aclw_pkg::IDX_FLAGS)
                    ? PWDATA[15:0] : 16'h0000;
  assign flags_nxt = mod_clear ? 16'h0000
                   : ((flags_r & ~flag_w1c) | flag_set);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      flags_r <= 16'h0000;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, enable and clear

  assign irq_evt[aclw_pkg::IRQ_EOL]  = done_ok & dec_is_eol;
  assign irq_evt[aclw_pkg::IRQ_CONV] = done_ok & (|dec_onehot);
  assign irq_evt[aclw_pkg::IRQ_ERR]  = start_ok & dec_rsv;
  assign irq_w1c = (wr && in_range && idx == aclw_pkg::IDX_IRQ_CLR)
                   ? PWDATA[aclw_pkg::IRQ_W-1:0] : 3'h0;
  assign irq_stat_nxt = mod_clear ? 3'h0
                      : ((irq_stat_r & ~irq_w1c) | irq_evt);
  assign irq_en_nxt = (wr && in_range && idx == aclw_pkg::IDX_IRQ_EN)
                      ? PWDATA[aclw_pkg::IRQ_W-1:0] : irq_en_r;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      irq_stat_r <= 3'h0;
      irq_en_r   <= 3'h0;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r   <= irq_en_nxt;
      irq_r      <= |(irq_stat_nxt & irq_en_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered decode outputs

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      out_type_r <= aclw_pkg::CT_NORMAL;
      out_wrap_r <= 1'b0;
      out_wait_r <= aclw_pkg::WAIT_NONE;
      out_href_r <= 1'b0;
      out_lref_r <= 1'b0;
      out_ch_r   <= 6'h00;
    end else begin
      out_type_r <= dec_type;
      out_wrap_r <= dec_wrap;
      out_wait_r <= dec_wait;
      out_href_r <= dec_href;
      out_lref_r <= dec_lref;
      out_ch_r   <= dec_ch;
    end
  end

  assign PRDATA            = prdata_r;
  assign PREADY            = pready_r;
  assign PSLVERR           = pslverr_r;
  assign CMD_TYPE          = out_type_r;
  assign LIST_WRAP         = out_wrap_r;
  assign WAIT_MODE         = out_wait_r;
  assign HIGH_REF_SEL      = out_href_r;
  assign LOW_REF_SEL       = out_lref_r;
  assign INPUT_CHANNEL_SEL = out_ch_r;
  assign CONV_FLAGS        = flags_r;
  assign CONV_HALT         = halt_r;
  assign IRQ               = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  chk_eol_clears: assert property (
    mod_clear |=> (eol_info_r == 2'h0))
    else $error("eol info not cleared");
  chk_eol_no_write: assert property (
    (wr && idx == aclw_pkg::IDX_EOL_INFO && !done_ok && !mod_clear)
    |=> $stable(eol_info_r))
    else $error("eol info changed by write");
  chk_eol_list_buf: assert property (
    (done_ok && dec_is_eol)
    |=> (eol_info_r == {$past(LIST_IN_USE), $past(BUFFER_IN_USE)}))
    else $error("eol info capture wrong");
  chk_eol_flag_sync: assert property (
    $changed(eol_info_r) && !$past(mod_clear) |-> flags_r[0])
    else $error("eol info updated without flag");
  chk_cmd_locked: assert property (
    (wr && !sma && (idx == aclw_pkg::IDX_CMD_B0
                 || idx == aclw_pkg::IDX_CMD_B1))
    |=> $stable(cmd_word_r))
    else $error("command written while locked");
  chk_type_action: assert property (
    (CMD_TYPE == aclw_pkg::CT_EOL_RUN)
    |-> (LIST_WRAP && WAIT_MODE == aclw_pkg::WAIT_NONE))
    else $error("type 10 action wrong");
  chk_eos_wait: assert property (
    (CMD_TYPE == aclw_pkg::CT_EOS)
    |-> (!LIST_WRAP && WAIT_MODE == aclw_pkg::WAIT_TRIG_OR_RST))
    else $error("type 01 action wrong");
  chk_flag_onehot: assert property (
    done_ok |-> $onehot0(flag_set[15:1]))
    else $error("more than one flag selected");
  chk_flag_sets: assert property (
    (done_ok && dec_onehot[1]) |=> flags_r[1])
    else $error("selected flag not set");
  chk_w1c_zero: assert property (
    (!done_ok && !mod_clear && wr && idx == aclw_pkg::IDX_FLAGS)
    |=> ((flags_r & ~$past(flag_w1c)) == flags_r)
        && ((flags_r | $past(flag_w1c)) == ($past(flags_r) | $past(flag_w1c))))
    else $error("flag write misbehaved");
  chk_error_halt: assert property (
    (start_ok && dec_rsv) |=> (CONV_HALT && irq_stat_r[aclw_pkg::IRQ_ERR]))
    else $error("reserved command did not halt");
  chk_irq_level: assert property (
    IRQ == |(irq_stat_r & irq_en_r))
    else $error("irq level mismatch");

  cov_eol_done: cover property (done_ok && dec_is_eol);
  cov_cmd_error: cover property (start_ok && dec_rsv);
  cov_locked_write: cover property (wr && !sma
                                    && idx == aclw_pkg::IDX_CMD_B0);
  cov_irq: cover property ($rose(IRQ));

endmodule

/* bench/adc_command_word_and_eol_info_tb_top.sv */
`timescale 1ns/1ps
module adc_command_word_and_eol_info_tb_top;
  logic                 CORE_CLK;
  logic                 SRST;
  logic                 PSEL;
  logic                 PENABLE;
  logic                 PWRITE;
  logic [11:0]          PADDR;
  logic [31:0]          PWDATA;
  logic [31:0]          PRDATA;
  logic                 PREADY;
  logic                 PSLVERR;
  logic                 CMD_START;
  logic                 CMD_DONE;
  logic                 LIST_IN_USE;
  logic                 BUFFER_IN_USE;
  logic [1:0]           CMD_TYPE;
  logic                 LIST_WRAP;
  aclw_pkg::aclw_wait_e WAIT_MODE;
  logic                 HIGH_REF_SEL;
  logic                 LOW_REF_SEL;
  logic [5:0]           INPUT_CHANNEL_SEL;
  logic [15:0]          CONV_FLAGS;
  logic                 CONV_HALT;
  logic                 IRQ;
  int                   mismatches;
  int                   checked;
  int                   seed;
  int                   cycles;
  logic [31:0]          rd;
  logic                 err;
  logic [1:0]           ty;
  logic [3:0]           fs;
  logic                 rm;
  logic                 hr;
  logic                 lr;
  logic                 ls;
  logic                 bs;
  logic [5:0]           ch;
  logic [7:0]           b0;
  logic [7:0]           b1;
  logic [7:0]           eol;

  aclw_top #(.NUM_AN(8)) uut (
    .CORE_CLK          (CORE_CLK),
    .SRST              (SRST),
    .PSEL              (PSEL),
    .PENABLE           (PENABLE),
    .PWRITE            (PWRITE),
    .PADDR             (PADDR),
    .PWDATA            (PWDATA),
    .PRDATA            (PRDATA),
    .PREADY            (PREADY),
    .PSLVERR           (PSLVERR),
    .CMD_START         (CMD_START),
    .CMD_DONE          (CMD_DONE),
    .LIST_IN_USE       (LIST_IN_USE),
    .BUFFER_IN_USE     (BUFFER_IN_USE),
    .CMD_TYPE          (CMD_TYPE),
    .LIST_WRAP         (LIST_WRAP),
    .WAIT_MODE         (WAIT_MODE),
    .HIGH_REF_SEL      (HIGH_REF_SEL),
    .LOW_REF_SEL       (LOW_REF_SEL),
    .INPUT_CHANNEL_SEL (INPUT_CHANNEL_SEL),
    .CONV_FLAGS        (CONV_FLAGS),
    .CONV_HALT         (CONV_HALT),
    .IRQ               (IRQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge CORE_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= {2'h0, idx, 2'h0};
    PWDATA  <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    @(posedge CORE_CLK);
    while (PREADY !== 1'b1) @(posedge CORE_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic st, input logic l, input logic b);
    @(posedge CORE_CLK);
    CMD_START     <= st;
    CMD_DONE      <= ~st;
    LIST_IN_USE   <= l;
    BUFFER_IN_USE <= b;
    @(posedge CORE_CLK);
    CMD_START     <= 1'b0;
    CMD_DONE      <= 1'b0;
    LIST_IN_USE   <= ~l;
    BUFFER_IN_USE <= ~b;
    @(posedge CORE_CLK);
  endtask

  task automatic settle;
    repeat (2) @(posedge CORE_CLK);
  endtask

  function automatic aclw_pkg::aclw_wait_e exp_wait(input logic [1:0] t,
                                                    input logic r);
    if (t == 2'h1) return aclw_pkg::WAIT_TRIG_OR_RST;
    if (t == 2'h3) return r ? aclw_pkg::WAIT_RST_THEN_TRIG
                            : aclw_pkg::WAIT_TRIG_OR_RST;
    return aclw_pkg::WAIT_NONE;
  endfunction

  function automatic logic [15:0] exp_flags(input logic [1:0] t,
                                            input logic [3:0] f);
    logic [15:0] v;
    v = 16'h0001 << f;
    v[0] = t[1];
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 27265;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    eol = 8'h00;
    SRST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    CMD_START = 1'b0;
    CMD_DONE = 1'b0;
    LIST_IN_USE = 1'b0;
    BUFFER_IN_USE = 1'b0;
    repeat (10) @(posedge CORE_CLK);
    SRST <= 1'b0;
    rchk(aclw_pkg::IDX_CTRL, 32'h0000_0000);
    rchk(aclw_pkg::IDX_EOL_INFO, 32'h0000_0000);
    rchk(aclw_pkg::IDX_CMD_B0, 32'h0000_0000);
    apb(1'b0, 8'h3F, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, aclw_pkg::IDX_CTRL, 32'h0000_0001);
    apb(1'b1, aclw_pkg::IDX_CMD_B0, 32'h0000_00C5);
    rchk(aclw_pkg::IDX_CMD_B0, 32'h0000_0000);
    apb(1'b1, aclw_pkg::IDX_IRQ_EN, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      ty = i[1:0];
      rm = i[2];
      fs = i[3:0];
      hr = 1'($random(seed));
      lr = 1'($random(seed));
      ls = 1'($random(seed));
      bs = 1'($random(seed));
      ch = {3'h2, 3'($random(seed))};
      b0 = {ty, 2'h0, fs};
      b1 = {hr, lr, ch};
      apb(1'b1, aclw_pkg::IDX_CTRL, {28'h0, rm, 3'h5});
      apb(1'b1, aclw_pkg::IDX_CMD_B0, {24'h0, b0});
      apb(1'b1, aclw_pkg::IDX_CMD_B1, {24'h0, b1});
      settle();
      chk(32'({CMD_TYPE, LIST_WRAP, WAIT_MODE}),
          32'({ty, ty[1], exp_wait(ty, rm)}));
      chk(32'({HIGH_REF_SEL, LOW_REF_SEL, INPUT_CHANNEL_SEL}),
          32'({hr, lr, ch}));
      rchk(aclw_pkg::IDX_CMD_B1, {24'h0, b1});
      pulse(1'b0, ls, bs);
      chk(32'(CONV_FLAGS), 32'(exp_flags(ty, fs)));
      chk(32'(IRQ), 32'(ty[1]));
      if (ty[1]) eol = {ls, bs, 6'h00};
      rchk(aclw_pkg::IDX_EOL_INFO, 32'(eol));
      apb(1'b1, aclw_pkg::IDX_IRQ_EN, 32'h0000_0000);
      settle();
      chk(32'(IRQ), 32'h0000_0000);
      apb(1'b1, aclw_pkg::IDX_IRQ_EN, 32'h0000_0001);
      apb(1'b1, aclw_pkg::IDX_FLAGS, 32'h0000_0000);
      settle();
      chk(32'(CONV_FLAGS), 32'(exp_flags(ty, fs)));
      apb(1'b1, aclw_pkg::IDX_IRQ_CLR, 32'h0000_0007);
      apb(1'b1, aclw_pkg::IDX_FLAGS, 32'h0000_FFFF);
      settle();
      chk(32'({IRQ, CONV_FLAGS}), 32'h0000_0000);
    end
    apb(1'b1, aclw_pkg::IDX_CMD_B0, 32'h0000_0080);
    pulse(1'b0, 1'b1, 1'b1);
    apb(1'b1, aclw_pkg::IDX_EOL_INFO, 32'h0000_0000);
    rchk(aclw_pkg::IDX_EOL_INFO, 32'h0000_00C0);
    apb(1'b1, aclw_pkg::IDX_CTRL, 32'h0000_0007);
    rchk(aclw_pkg::IDX_EOL_INFO, 32'h0000_0000);
    apb(1'b1, aclw_pkg::IDX_CTRL, 32'h0000_0005);
    pulse(1'b0, 1'b1, 1'b0);
    apb(1'b1, aclw_pkg::IDX_CTRL, 32'h0000_0004);
    rchk(aclw_pkg::IDX_EOL_INFO, 32'h0000_0000);
    chk(32'(CONV_FLAGS), 32'h0000_0000);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, aclw_pkg::IDX_CTRL, 32'h0000_0005);
      apb(1'b1, aclw_pkg::IDX_CMD_B0, j ? 32'h0000_0090 : 32'h0000_0080);
      apb(1'b1, aclw_pkg::IDX_CMD_B1, j ? 32'h0000_0010 : 32'h0000_0003);
      pulse(1'b1, 1'b0, 1'b0);
      chk(32'(CONV_HALT), 32'h0000_0001);
      rchk(aclw_pkg::IDX_IRQ_STAT, 32'h0000_0004);
      pulse(1'b0, 1'b1, 1'b1);
      chk(32'(CONV_FLAGS), 32'h0000_0000);
      apb(1'b1, aclw_pkg::IDX_CTRL, 32'h0000_0004);
      settle();
      chk(32'(CONV_HALT), 32'h0000_0000);
    end
    end_of_test();
  end
endmodule
